// >>> hdl/toc_consts.vh
// constants for the two-channel output-compare timer block
// assumes inclusion by the single design file toc_top.v
`ifndef TOC_CONSTS_VH
`define TOC_CONSTS_VH

// register byte addresses on the apb bus
`define TOC_ADDR_CMP1_HI   8'h00
`define TOC_ADDR_CMP1_LO   8'h04
`define TOC_ADDR_CMP2_HI   8'h08
`define TOC_ADDR_CMP2_LO   8'h0C
`define TOC_ADDR_CTRL1     8'h10
`define TOC_ADDR_CTRL2     8'h14
`define TOC_ADDR_STATUS    8'h18
`define TOC_ADDR_COUNT     8'h1C
`define TOC_ADDR_IRQ_EN    8'h20
`define TOC_ADDR_IRQ_CLR   8'h24

// reset values
`define TOC_CMP_RESET      16'h8000
`define TOC_CTRL_RESET     8'h00

// control_one fields
`define TOC_C1_LVL1        0
`define TOC_C1_LVL2        1
`define TOC_C1_IE          2

// control_two fields
`define TOC_C2_OE1         0
`define TOC_C2_OE2         1
`define TOC_C2_CC_LO       2
`define TOC_C2_CC_HI       3

// prescaler_select codes
`define TOC_CC_DIV2        2'h0
`define TOC_CC_DIV4        2'h1
`define TOC_CC_DIV8        2'h2
`define TOC_CC_EXT         2'h3

`endif

// >>> hdl/toc_top.v
// two-channel output compare unit of a 16-bit free-running timer, apb slave
// assumes inputs synchronous to pclk and an external clock well below pclk/2
//
// Summary of operation
// - Each channel compares its 16-bit value with the counter on every timer tick.
// - There are two independent channels, each with value, flag, enable and level.
// - A counter equal to a channel value sets that channel's match flag.
// - On a match with output enable set, the pin takes the programmed level.
// - A match requests timer_irq only with interrupt enable set and cpu mask clear.
// - Each compare value resets to 8000h.
// - Compare values are read/write by software and never changed by hardware.
// - Each compare output latch is held low during reset.
// - A flag clears after a status read with it set, then a low-byte access.
// - A high-byte write inhibits matches on that channel until the low byte is written.
// - A low-byte write re-enables matching and completes the flag clear.
// - The timer tick is pclk divided by 2, 4 or 8 from a two-bit select.
// - The counter may instead advance on each external clock period.
`timescale 1ns/100ps
`include "toc_consts.vh"

module toc_top
(
	// apb clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// timer inputs
	input  wire        ext_clk_in,
	input  wire        cpu_int_mask,
	// compare outputs
	output wire [1:0]  compare_output_pin,
	output wire [1:0]  compare_output_oe,
	output wire        timer_irq,
	output wire        irq
);

	localparam CH = 2;

	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & penable & ~pwrite;

	// per-channel state sits in the generate loop; the wires here collect it
	wire [16*CH-1:0] compare_value_w;
	reg  [7:0]       control_one_q;
	reg  [7:0]       control_two_q;
	reg  [15:0]      counter_value_q;
	wire [CH-1:0]    compare_match_flag_w;
	wire [CH-1:0]    pin_w;
	wire [CH-1:0]    irq_stat_w;
	reg  [CH-1:0]    irq_en_q;
	reg  [2:0]       div_q;
	reg  [1:0]       ext_q;
	reg  [31:0]      rd_mux;

	wire [1:0] prescaler_select =
		control_two_q[`TOC_C2_CC_HI:`TOC_C2_CC_LO];

	// byte-lane access decode, shared by every channel
	function hit;
		input [7:0] addr;
		input [7:0] want;
		begin
			hit = (addr == want);
		end
	endfunction

	// address of a channel's compare byte; kept 8 bits wide on purpose
	function [7:0] cmp_addr;
		input integer ch;
		input         high;
		begin
			if (ch == 0)
				cmp_addr = high ? `TOC_ADDR_CMP1_HI : `TOC_ADDR_CMP1_LO;
			else
				cmp_addr = high ? `TOC_ADDR_CMP2_HI : `TOC_ADDR_CMP2_LO;
		end
	endfunction

	// zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// the divider runs freely and a new select applies at once against the
	// running count, so the first period after a change may be short
	// prescaler divider
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_q <= 3'h0;
		else
			div_q <= div_q + 3'h1;
	end

	// the external clock must hold each level for at least one pclk cycle
	// or an edge is lost; idle low matches the reset value, so no false edge
	// external clock edge detect
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_q <= 2'h0;
		else
			ext_q <= {ext_q[0], ext_clk_in};
	end

	reg tick;
	always @*
	begin
		case (prescaler_select)
			`TOC_CC_DIV2: tick = (div_q[0] == 1'b1);
			`TOC_CC_DIV4: tick = (div_q[1:0] == 2'h3);
			`TOC_CC_DIV8: tick = (div_q == 3'h7);
			`TOC_CC_EXT:  tick = ext_q[0] & ~ext_q[1];
			default:      tick = 1'b0;
		endcase
	end

	// resets to zero; only ticks move it, software cannot write it
	// free-running counter with natural wrap
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			counter_value_q <= 16'h0000;
		else if (tick)
			counter_value_q <= counter_value_q + 16'h0001;
	end

	// control registers; interrupt enable holds one bit per channel
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			control_one_q <= `TOC_CTRL_RESET;
			control_two_q <= `TOC_CTRL_RESET;
			irq_en_q      <= {CH{1'b0}};
		end
		else if (wr_en)
		begin
			if (hit(paddr, `TOC_ADDR_CTRL1))
				control_one_q <= pwdata[7:0];
			if (hit(paddr, `TOC_ADDR_CTRL2))
				control_two_q <= pwdata[7:0];
			if (hit(paddr, `TOC_ADDR_IRQ_EN))
				irq_en_q <= pwdata[CH-1:0];
		end
	end

	// a status read is the first step of clearing a match flag
	wire status_rd = rd_en & hit(paddr, `TOC_ADDR_STATUS);

	genvar i;
	generate
		for (i = 0; i < CH; i = i + 1)
		begin : g_ch
			wire [7:0]  a_hi   = cmp_addr(i, 1'b1);
			wire [7:0]  a_lo   = cmp_addr(i, 1'b0);
			wire        hi_wr  = wr_en & hit(paddr, a_hi);
			wire        lo_wr  = wr_en & hit(paddr, a_lo);
			wire        lo_acc = psel & penable & hit(paddr, a_lo);
			wire        oe     = control_two_q[`TOC_C2_OE1 + i];
			wire        level  = control_one_q[`TOC_C1_LVL1 + i];
			wire        clr_wr = wr_en & pwdata[i] &
				hit(paddr, `TOC_ADDR_IRQ_CLR);
			// each channel owns its state, so every bit has one driver
			reg  [15:0] value_q;
			reg         inhibit_q;
			reg         flag_q;
			reg         armed_q;
			reg         pin_q;
			reg         irq_stat_q;
			wire        match;

			assign match = tick & ~inhibit_q &
				(counter_value_q == value_q);

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					value_q <= `TOC_CMP_RESET;
				else if (hi_wr)
					value_q[15:8] <= pwdata[7:0];
				else if (lo_wr)
					value_q[7:0] <= pwdata[7:0];
			end

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					inhibit_q <= 1'b0;
				else if (hi_wr)
					inhibit_q <= 1'b1;
				else if (lo_wr)
					inhibit_q <= 1'b0;
			end

			// two-step clear
			// a match in the clearing cycle wins, so no event is lost
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					flag_q <= 1'b0;
				else if (match)
					flag_q <= 1'b1;
				else if (lo_acc & armed_q)
					flag_q <= 1'b0;
			end

			// first step: software was shown the flag set by a status read;
			// arming on the returned data, not the live flag, means a match
			// landing during the read is never cleared unseen
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					armed_q <= 1'b0;
				else if (status_rd & prdata[i])
					armed_q <= 1'b1;
				else if (lo_acc)
					armed_q <= 1'b0;
			end

			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					pin_q <= 1'b0;
				else if (match & oe)
					pin_q <= level;
			end

			// sticky event bit; a set wins over a clear in the same cycle
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					irq_stat_q <= 1'b0;
				else if (match)
					irq_stat_q <= 1'b1;
				else if (clr_wr)
					irq_stat_q <= 1'b0;
			end

			assign compare_value_w[16*i +: 16] = value_q;
			assign compare_match_flag_w[i]     = flag_q;
			assign pin_w[i]                    = pin_q;
			assign irq_stat_w[i]               = irq_stat_q;
			assign compare_output_oe[i]        = oe;
		end
	endgenerate

	assign compare_output_pin = pin_w;

	// interrupt gated by enable and cpu mask
	assign timer_irq = control_one_q[`TOC_C1_IE] & ~cpu_int_mask &
		(|compare_match_flag_w);
	// general interrupt line: sticky match events masked per channel
	assign irq = |(irq_stat_w & irq_en_q);

	// read mux; unmapped reads return zero
	always @*
	begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			`TOC_ADDR_CMP1_HI: rd_mux[7:0] = compare_value_w[15:8];
			`TOC_ADDR_CMP1_LO: rd_mux[7:0] = compare_value_w[7:0];
			`TOC_ADDR_CMP2_HI: rd_mux[7:0] = compare_value_w[31:24];
			`TOC_ADDR_CMP2_LO: rd_mux[7:0] = compare_value_w[23:16];
			`TOC_ADDR_CTRL1:   rd_mux[7:0] = control_one_q;
			`TOC_ADDR_CTRL2:   rd_mux[7:0] = control_two_q;
			`TOC_ADDR_STATUS:  rd_mux[CH-1:0] = compare_match_flag_w;
			`TOC_ADDR_COUNT:   rd_mux[15:0] = counter_value_q;
			`TOC_ADDR_IRQ_EN:  rd_mux[CH-1:0] = irq_en_q;
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// read data is captured in the setup cycle and stands through the
	// access phase; the status value shown is the one the flag clear
	// arms on, one cycle before the access edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite)
			prdata <= rd_mux;
	end

endmodule

// >>> verif/toc_top_chk.sv
// port checker for the two-channel output-compare timer
// assumes binding onto toc_top with a zero-wait apb slave
`timescale 1ns/100ps
module toc_chk
(
	// apb
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	input wire [31:0] prdata,
	// timer
	input wire        cpu_int_mask,
	input wire [1:0]  compare_output_pin,
	input wire [1:0]  compare_output_oe,
	input wire        timer_irq,
	input wire        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = psel && penable && !pwrite;
	wire wr = psel && penable && pwrite;
	property p_rdy; psel && penable |-> pready && !pslverr; endproperty
	a_rdy: assert property (p_rdy) else $error("apb answer late");
	property p_msk; timer_irq |-> !cpu_int_mask; endproperty
	a_msk: assert property (p_msk) else $error("irq while masked");
	property p_ie; wr && paddr == 8'h10 && !pwdata[2] |=> !timer_irq;
	endproperty
	a_ie: assert property (p_ie) else $error("irq without enable");
	property p_oe; wr && paddr == 8'h14 |=>
		compare_output_oe == $past(pwdata[1:0]); endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	property p_st; rd && paddr == 8'h18 |-> prdata[31:2] == 0; endproperty
	a_st: assert property (p_st) else $error("status width");
	property p_cmp; rd && paddr < 8'h10 |-> prdata[31:8] == 0; endproperty
	a_cmp: assert property (p_cmp) else $error("byte read width");
	property p_unm; rd && paddr >= 8'h24 |-> prdata == 0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_irq; wr && paddr == 8'h20 && pwdata[1:0] == 0 |=> !irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not masked");
	// async reset: checked while reset is low, so no disable here
	property p_rst; disable iff (1'b0)
		!presetn |-> compare_output_pin == 0 && compare_output_oe == 0;
	endproperty
	a_rst: assert property (p_rst) else $error("pin not low");
	cover property (timer_irq);
	cover property (irq);
	cover property ($rose(compare_output_pin[0]));
endmodule
bind toc_top toc_chk toc_chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.cpu_int_mask(cpu_int_mask), .compare_output_pin(compare_output_pin),
	.compare_output_oe(compare_output_oe), .timer_irq(timer_irq),
	.irq(irq));

// >>> verif/toc_top_tb.sv
// self-checking bench for the output-compare timer
// assumes toc_top answers apb with zero wait states
`timescale 1ns/100ps
module toc_top_tb;
	reg        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	reg        ext_clk_in = 0, cpu_int_mask = 0;
	reg [7:0]  paddr = 0;
	reg [31:0] pwdata = 0, rd;
	reg [31:0] mdl [0:5];
	wire       pready, pslverr, timer_irq, irq;
	wire [31:0] prdata;
	wire [1:0] compare_output_pin, compare_output_oe;
	integer    mismatches = 0, samples_checked = 0, seed = 32'h316c, i, c, d;
	toc_top toc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .pslverr(pslverr), .prdata(prdata),
		.ext_clk_in(ext_clk_in), .cpu_int_mask(cpu_int_mask),
		.compare_output_pin(compare_output_pin),
		.compare_output_oe(compare_output_oe), .timer_irq(timer_irq),
		.irq(irq));
	initial
		forever #10 pclk = ~pclk;
	task chk(input [31:0] got, input [31:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	// ends one idle edge later so back-to-back calls never redrive psel
	task xfer(input w, input [7:0] a, input [31:0] v);
	begin
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	end
	endtask
	task wrm(input [7:0] r, input [31:0] v);
	begin
		mdl[r] = v;
		xfer(1, r << 2, v);
	end
	endtask
	task rdm(input [7:0] r);
	begin
		xfer(0, r << 2, 0);
		chk(rd, mdl[r]);
	end
	endtask
	task setc(input [7:0] r, input integer v);
	begin
		wrm(r, v >> 8 & 255);
		wrm(r + 1, v & 255);
	end
	endtask
	task results;
	begin
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches = mismatches + 1;
		results;
	end
	initial
	begin
		mdl[0] = 8'h80; mdl[1] = 0; mdl[2] = 8'h80;
		mdl[3] = 0; mdl[4] = 0; mdl[5] = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (i = 0; i < 6; i = i + 1)
			rdm(i);
		xfer(1, 8'h20, 3);
		for (i = 0; i < 4; i = i + 1)
		begin
			d = 2 << i;
			wrm(5, i << 2);
			xfer(0, 8'h1C, 0);
			c = rd;
			if (i < 3)
				repeat (8 * d - 3) @(posedge pclk);
			else
				repeat (5)
				begin
					ext_clk_in <= 1'b1;
					repeat (2) @(posedge pclk);
					ext_clk_in <= 1'b0;
					repeat (2) @(posedge pclk);
				end
			xfer(0, 8'h1C, 0);
			chk(rd - c & 16'hFFFF, i < 3 ? 8 : 5);
		end
		wrm(5, 3);
		c = $random(seed) & 3;
		wrm(4, 4 | c);
		xfer(0, 8'h1C, 0);
		d = rd;
		setc(0, d + 40);
		setc(2, d + 60);
		repeat (150) @(posedge pclk);
		chk(compare_output_pin, c);
		chk(timer_irq, 1);
		chk(irq, 1);
		cpu_int_mask <= 1'b1;
		@(posedge pclk);
		chk(timer_irq, 0);
		cpu_int_mask <= 1'b0;
		xfer(1, 8'h20, 0);
		chk(irq, 0);
		xfer(1, 8'h20, 3);
		xfer(1, 8'h24, 1);
		chk(irq, 1);
		xfer(1, 8'h24, 2);
		chk(irq, 0);
		xfer(0, 8'h24, 0);
		chk(rd, 0);
		xfer(0, 8'h28, 0);
		chk(rd, 0);
		rdm(3);
		xfer(0, 8'h18, 0);
		chk(rd, 3);
		rdm(3);
		xfer(0, 8'h18, 0);
		chk(rd, 1);
		wrm(0, mdl[0]);
		xfer(0, 8'h18, 0);
		wrm(1, mdl[1]);
		xfer(0, 8'h18, 0);
		chk(rd, 0);
		chk(timer_irq, 0);
		xfer(0, 8'h1C, 0);
		wrm(0, rd + 256 >> 8 & 255);
		repeat (1200) @(posedge pclk);
		xfer(0, 8'h18, 0);
		chk(rd, 0);
		for (i = 0; i < 6; i = i + 1)
			rdm(i);
		wrm(4, 0);
		presetn <= 1'b0;
		@(posedge pclk);
		chk({compare_output_oe, compare_output_pin}, 0);
		presetn <= 1'b1;
		@(posedge pclk);
		mdl[0] = 8'h80;
		mdl[5] = 0;
		rdm(0);
		rdm(5);
		results;
	end
endmodule
